// file: verilog/fca_pkg.sv
// shared constants and types of the flash command host
package fca_pkg;
	localparam int CLK_MHZ     = 10;
	localparam int SYNC_CYC    = 2;
	// bus cycle times in ns, least values, rounded up to clocks
	localparam int T_WE_NS     = 150;
	localparam int T_ACC_NS    = 100;
	localparam int T_PD_NS     = 100;
	localparam int T_RDY_NS    = 1000;
	localparam int T_WAKE_NS   = 1000;
	localparam int WE_CYC      = (T_WE_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
	localparam int PD_CYC      = (T_PD_NS * CLK_MHZ + 999) / 1000;
	localparam int RDY_CYC     = (T_RDY_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_CYC    = (T_WAKE_NS * CLK_MHZ + 999) / 1000;

	localparam int ADDR_W      = 21;
	localparam int DATA_W      = 16;
	localparam int BLK_LSB     = 16;

	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_WDATA  = 4'h2;
	localparam logic [3:0] REG_RDATA  = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;

	localparam int CTRL_GO_WR  = 0;
	localparam int CTRL_GO_RD  = 1;
	localparam int CTRL_PDOWN  = 2;
	localparam int CTRL_UNPROT = 3;
	localparam int CTRL_WIDE   = 4;

	localparam int ST_CYC_BUSY = 0;
	localparam int ST_DEV_BUSY = 1;
	localparam int ST_READ_OK  = 2;
	localparam int ST_WRITE_OK = 3;
	localparam int ST_DONE     = 4;
	localparam int ST_REFUSED  = 5;

	localparam logic [2:0] CTRL_RST = 3'h0;

	typedef enum logic [2:0] {
		FCA_IDLE,
		FCA_W_SETUP,
		FCA_W_LOW,
		FCA_W_HOLD,
		FCA_R_ACC,
		FCA_R_TAKE
	} fca_state_t;

	typedef struct packed {
		logic              ce0_n;
		logic              ce1_n;
		logic              oe_n;
		logic              we_n;
		logic              rp_n;
		logic              wp_n;
		logic              byte_n;
		logic [ADDR_W-1:0] addr;
	} fca_pins_t;

	localparam fca_pins_t PINS_RST = '{ce0_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
		rp_n: 1'b0, wp_n: 1'b0, byte_n: 1'b0, addr: '0};
endpackage

// file: verilog/fca_sync.sv
// two-flop synchroniser for flash pins entering the mclk domain
`timescale 1ns/1ps
`default_nettype none
module fca_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= RST_VAL;
			dout   <= RST_VAL;
		end
		else
		begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: verilog/fca_host.sv
// host controller driving the flash command front end over its pins
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fca_host #(
	parameter int WE_CYCLES   = fca_pkg::WE_CYC,
	parameter int ACC_CYCLES  = fca_pkg::ACC_CYC,
	parameter int PD_CYCLES   = fca_pkg::PD_CYC,
	parameter int RDY_CYCLES  = fca_pkg::RDY_CYC,
	parameter int WAKE_CYCLES = fca_pkg::WAKE_CYC
) (
	input  wire logic                       mclk,
	input  wire logic                       rstn,
	input  wire logic [3:0]                 reg_addr,
	input  wire logic [31:0]                reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [31:0]                reg_rdata,
	output fca_pkg::fca_pins_t              pins_q,
	output logic      [fca_pkg::DATA_W-1:0] dq_out,
	output logic                            dq_oe,
	input  wire logic [fca_pkg::DATA_W-1:0] dq_in,
	input  wire logic                       sts_in
);
	initial
	begin
		if (WE_CYCLES < 1 || ACC_CYCLES < 3 || PD_CYCLES < 1 ||
			RDY_CYCLES < 1 || WAKE_CYCLES < 1 || WAKE_CYCLES > 65535 || RDY_CYCLES > 65535)
			$error("fca_host: timing parameters out of range");
	end

	logic                       rst_m_q, rst_n;
	fca_pkg::fca_state_t        state_q;
	logic [7:0]                 cnt_q;
	logic [15:0]                wake_q;
	logic [7:0]                 pd_q;
	logic [2:0]                 ctrl_q;
	logic [fca_pkg::ADDR_W-1:0] addr_q;
	logic [fca_pkg::DATA_W-1:0] wdata_q, rdata_q, dq_s;
	logic                       sts_s, sts_prev_q, done_q, refused_q;
	logic                       read_ok, write_ok, go_wr, go_rd, wr_ctrl, wr_stat;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_m_q <= 1'b0;
			rst_n   <= 1'b0;
		end
		else
		begin
			rst_m_q <= 1'b1;
			rst_n   <= rst_m_q;
		end
	end

	// activity pin is open-drain: the bench pulls it up when released
	fca_sync #(.W(1), .RST_VAL(1'b1)) u_sts_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (sts_in),
		.dout  (sts_s)
	);

	fca_sync #(.W(fca_pkg::DATA_W), .RST_VAL('0)) u_dq_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (dq_in),
		.dout  (dq_s)
	);

	assign wr_ctrl  = reg_wr && reg_addr == fca_pkg::REG_CTRL;
	assign wr_stat  = reg_wr && reg_addr == fca_pkg::REG_STATUS;
	assign read_ok  = pins_q.rp_n && wake_q >= 16'(RDY_CYCLES);
	assign write_ok = pins_q.rp_n && wake_q >= 16'(WAKE_CYCLES);
	assign go_wr    = wr_ctrl && reg_wdata[fca_pkg::CTRL_GO_WR] && state_q == fca_pkg::FCA_IDLE
		&& write_ok;
	assign go_rd    = wr_ctrl && reg_wdata[fca_pkg::CTRL_GO_RD] && !reg_wdata[fca_pkg::CTRL_GO_WR]
		&& state_q == fca_pkg::FCA_IDLE && read_ok;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q  <= fca_pkg::CTRL_RST;
			addr_q  <= '0;
			wdata_q <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= reg_wdata[fca_pkg::CTRL_WIDE:fca_pkg::CTRL_PDOWN];
			if (reg_wr && reg_addr == fca_pkg::REG_ADDR)
				addr_q <= reg_wdata[fca_pkg::ADDR_W-1:0];
			if (reg_wr && reg_addr == fca_pkg::REG_WDATA)
				wdata_q <= reg_wdata[fca_pkg::DATA_W-1:0];
		end
	end

	// power-down hold, abort of a running operation is the device's job
	// rp kept low at least the minimum even if software drops it at once
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pd_q   <= '0;
			wake_q <= '0;
		end
		else
		begin
			if (!pins_q.rp_n && pd_q < 8'(PD_CYCLES))
				pd_q <= pd_q + 8'd1;
			else if (pins_q.rp_n)
				pd_q <= '0;
			// count from rp release; device wakes in read-array mode
			if (!pins_q.rp_n)
				wake_q <= '0;
			else if (wake_q != 16'hffff)
				wake_q <= wake_q + 16'd1;
		end
	end

	// address and data stay put across the rising edge of write enable
	// chip selects dropped between cycles so the device idles in standby
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= fca_pkg::FCA_IDLE;
			cnt_q   <= '0;
			pins_q  <= fca_pkg::PINS_RST;
			dq_out  <= '0;
			dq_oe   <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			pins_q.wp_n   <= ctrl_q[fca_pkg::CTRL_UNPROT - fca_pkg::CTRL_PDOWN];
			pins_q.byte_n <= ctrl_q[fca_pkg::CTRL_WIDE - fca_pkg::CTRL_PDOWN];
			// enter power-down only between bus cycles
			if (state_q == fca_pkg::FCA_IDLE && !go_wr && !go_rd)
				pins_q.rp_n <= !(ctrl_q[0] || (!pins_q.rp_n && pd_q < 8'(PD_CYCLES)));
			case (state_q)
				fca_pkg::FCA_IDLE:
				begin
					pins_q.ce0_n <= 1'b1;
					pins_q.ce1_n <= 1'b1;
					pins_q.oe_n  <= 1'b1;
					pins_q.we_n  <= 1'b1;
					dq_oe        <= 1'b0;
					if (go_wr)
					begin
						// every command byte is one plain write cycle
						// lock commands go the same way, no shortcut
						pins_q.addr  <= addr_q;
						pins_q.ce0_n <= 1'b0;
						pins_q.ce1_n <= 1'b0;
						dq_out       <= wdata_q;
						dq_oe        <= 1'b1;
						state_q      <= fca_pkg::FCA_W_SETUP;
					end
					else if (go_rd)
					begin
						// data comes from whatever source the last mode command chose
						pins_q.addr  <= addr_q;
						pins_q.ce0_n <= 1'b0;
						pins_q.ce1_n <= 1'b0;
						pins_q.oe_n  <= 1'b0;
						cnt_q        <= 8'(ACC_CYCLES - 1);
						state_q      <= fca_pkg::FCA_R_ACC;
					end
				end
				fca_pkg::FCA_W_SETUP:
				begin
					pins_q.we_n <= 1'b0;
					cnt_q       <= 8'(WE_CYCLES - 1);
					state_q     <= fca_pkg::FCA_W_LOW;
				end
				fca_pkg::FCA_W_LOW:
				begin
					if (cnt_q == 8'd0)
					begin
						pins_q.we_n <= 1'b1;
						state_q     <= fca_pkg::FCA_W_HOLD;
					end
					else
						cnt_q <= cnt_q - 8'd1;
				end
				fca_pkg::FCA_W_HOLD:
				begin
					pins_q.ce0_n <= 1'b1;
					pins_q.ce1_n <= 1'b1;
					dq_oe        <= 1'b0;
					state_q      <= fca_pkg::FCA_IDLE;
				end
				fca_pkg::FCA_R_ACC:
				begin
					// access time plus the two synchroniser stages
					if (cnt_q == 8'd0)
						state_q <= fca_pkg::FCA_R_TAKE;
					else
						cnt_q <= cnt_q - 8'd1;
				end
				fca_pkg::FCA_R_TAKE:
				begin
					// in byte mode only the low lane carries data
					rdata_q      <= pins_q.byte_n ? dq_s : {8'h00, dq_s[7:0]};
					pins_q.ce0_n <= 1'b1;
					pins_q.ce1_n <= 1'b1;
					pins_q.oe_n  <= 1'b1;
					state_q      <= fca_pkg::FCA_IDLE;
				end
				default:
					state_q <= fca_pkg::FCA_IDLE;
			endcase
		end
	end

	// low level means busy; a rising edge marks the end of an operation
	// software still reads the device status to see the outcome
	// done tells software to send read-array before array reads
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sts_prev_q <= 1'b1;
			done_q     <= 1'b0;
			refused_q  <= 1'b0;
		end
		else
		begin
			sts_prev_q <= sts_s;
			// release while powered down is not a completion
			if (sts_s && !sts_prev_q && pins_q.rp_n)
				done_q <= 1'b1;
			else if (wr_stat && reg_wdata[fca_pkg::ST_DONE])
				done_q <= 1'b0;
			if (wr_ctrl && (reg_wdata[fca_pkg::CTRL_GO_WR] || reg_wdata[fca_pkg::CTRL_GO_RD])
				&& !go_wr && !go_rd)
				refused_q <= 1'b1;
			else if (wr_stat && reg_wdata[fca_pkg::ST_REFUSED])
				refused_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			case (reg_addr)
				fca_pkg::REG_CTRL:   reg_rdata <= {27'h0, ctrl_q, 2'h0};
				fca_pkg::REG_ADDR:   reg_rdata <= {11'h0, addr_q};
				fca_pkg::REG_WDATA:  reg_rdata <= {16'h0, wdata_q};
				fca_pkg::REG_RDATA:  reg_rdata <= {16'h0, rdata_q};
				fca_pkg::REG_STATUS: reg_rdata <= {26'h0, refused_q, done_q, write_ok, read_ok,
					!sts_s, state_q != fca_pkg::FCA_IDLE};
				default:             reg_rdata <= '0;
			endcase
		end
		else
			reg_rdata <= '0;
	end

	sequence s_we_low;
		!pins_q.we_n [*2];
	endsequence

	sequence s_we_release;
		pins_q.we_n && !pins_q.ce0_n && dq_oe;
	endsequence

	// write pulse length and data held over the latching edge
	chk_we_pulse_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(pins_q.we_n) |-> s_we_low ##1 s_we_release)
		else $error("write pulse shape wrong");
	// address stable while write enable low
	chk_addr_stable: assert property (@(posedge mclk) disable iff (!rst_n)
		!pins_q.we_n |-> $stable(pins_q.addr) && $stable(dq_out) && dq_oe)
		else $error("address or data moved during write");
	// no write or read without both selects
	chk_sel_both: assert property (@(posedge mclk) disable iff (!rst_n)
		(!pins_q.we_n || !pins_q.oe_n) |-> !pins_q.ce0_n && !pins_q.ce1_n)
		else $error("strobe without chip select");
	// writes wait for the wake time
	chk_wake_write: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(pins_q.we_n) |-> wake_q > 16'(WAKE_CYCLES))
		else $error("write before wake time");
	// reads wait for the reset time
	chk_wake_read: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(pins_q.oe_n) |-> wake_q > 16'(RDY_CYCLES))
		else $error("read before reset time");
	// power-down only outside a bus cycle
	chk_pd_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		!pins_q.rp_n |-> pins_q.ce0_n && pins_q.we_n && pins_q.oe_n)
		else $error("bus active in power-down");
	chk_pd_min: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(pins_q.rp_n) |-> $past(pd_q) >= 8'(PD_CYCLES))
		else $error("power-down too short");
	// completion of the sequencer is caught
	chk_done_set: assert property (@(posedge mclk) disable iff (!rst_n)
		(sts_s && !sts_prev_q && pins_q.rp_n) |=> done_q)
		else $error("completion missed");
	// read data taken from the pins at the end of access
	chk_read_take: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == fca_pkg::FCA_R_TAKE && pins_q.byte_n) |=> rdata_q == $past(dq_s))
		else $error("read data not captured");
	// never drive data while outputs enabled
	chk_no_fight: assert property (@(posedge mclk) disable iff (!rst_n)
		!(dq_oe && !pins_q.oe_n))
		else $error("bus contention");
endmodule
`default_nettype wire

// file: tb/fca_dev_model.sv
// behavioural flash device answering the host controller's pins
`timescale 1ns/1ps
`default_nettype none
module fca_dev_model #(
	parameter logic [7:0] CMD_ARR = 8'h01,
	parameter logic [7:0] CMD_STS = 8'h02,
	parameter logic [7:0] CMD_WR  = 8'h03,
	parameter logic [7:0] CMD_ER  = 8'h04,
	parameter logic [7:0] CMD_OK  = 8'h05,
	parameter logic [7:0] CMD_LK  = 8'h06,
	parameter int         BUSY    = 20
) (
	input  wire logic               tick,
	input  wire fca_pkg::fca_pins_t pins,
	input  wire logic [15:0]        dq_wire,
	output logic      [15:0]        dq_drv,
	output logic                    dq_en,
	output logic                    sts_low
);
	logic [15:0] mem [int];
	logic [31:0] lock_q = '0;
	logic [7:0]  pend_q = '0;
	logic        stat_q = 1'b0;
	int          busy   = 0;
	logic        go;
	logic        bad;
	logic [15:0] rdv;
	logic [7:0]  b;
	logic [4:0]  blk;
	logic [19:0] wa;

	assign blk = pins.addr[20:16];
	assign wa = pins.addr[20:1];
	assign dq_en = !pins.ce0_n && !pins.ce1_n && !pins.oe_n && pins.rp_n;
	assign sts_low = busy != 0;

	always @*
	begin
		rdv = mem.exists(wa) ? mem[wa] : 16'hffff;
		if (stat_q)
			rdv = {8'h00, busy != 0 ? 8'h00 : 8'h80};
		b = pins.addr[0] ? rdv[15:8] : rdv[7:0];
		dq_drv = pins.byte_n ? rdv : {~b, b};
	end

	always @(posedge tick)
	begin
		if (!pins.rp_n)
		begin
			busy = 0;
			pend_q = '0;
			stat_q = 1'b0;
		end
		else if (busy != 0)
			busy = busy - 1;
	end

	always @(posedge pins.we_n)
	begin
		if (!pins.ce0_n && !pins.ce1_n && pins.rp_n && busy == 0)
		begin
			bad = lock_q[blk] && !pins.wp_n;
			go = 1'b0;
			if (pend_q == CMD_WR && !bad)
			begin
				mem[wa] = dq_wire;
				go = 1'b1;
			end
			if (pend_q == CMD_ER && dq_wire[7:0] == CMD_OK && !bad)
			begin
				for (int k = 0; k < 32768; k++)
					mem.delete(int'({blk, k[14:0]}));
				go = 1'b1;
			end
			if (pend_q == CMD_LK && dq_wire[7:0] == CMD_OK && pins.wp_n)
			begin
				lock_q[blk] = 1'b1;
				go = 1'b1;
			end
			if (pend_q != 0 || dq_wire[7:0] == CMD_STS)
				stat_q = 1'b1;
			if (pend_q == 0 && dq_wire[7:0] == CMD_ARR)
				stat_q = 1'b0;
			if (pend_q == 0 && dq_wire[7:0] inside {CMD_WR, CMD_ER, CMD_LK})
				pend_q = dq_wire[7:0];
			else
				pend_q = 8'h00;
			if (go)
				busy = BUSY;
		end
	end
endmodule
`default_nettype wire

// file: tb/test_fca_host.sv
// self-checking bench for the flash host against the device model
`timescale 1ns/1ps
`default_nettype none
module test_fca_host;
	localparam logic [7:0] C_ARR = 8'h01;
	localparam logic [7:0] C_STS = 8'h02;
	localparam logic [7:0] C_WR = 8'h03;
	localparam logic [7:0] C_ER = 8'h04;
	localparam logic [7:0] C_OK = 8'h05;
	localparam logic [7:0] C_LK = 8'h06;
	logic               mclk;
	logic               rstn;
	logic [3:0]         reg_addr;
	logic [31:0]        reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [31:0]        reg_rdata;
	fca_pkg::fca_pins_t pins_q;
	logic [15:0]        dq_out;
	logic [15:0]        dq_in;
	logic [15:0]        dq_drv;
	logic [15:0]        dq_last;
	logic               dq_oe;
	logic               dq_en;
	logic               sts_low;
	logic               chk;
	logic               chk_d;
	logic [31:0]        exp_q[$];
	logic [31:0]        e;
	logic [31:0]        v;
	logic [31:0]        cfg;
	logic [31:0]        rnd;
	logic [20:0]        ad[2];
	logic [15:0]        dt[2];
	int                 n_mismatch;
	int                 tests_run;

	fca_host u_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_q(pins_q),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .sts_in(!sts_low));
	fca_dev_model #(.CMD_ARR(C_ARR), .CMD_STS(C_STS), .CMD_WR(C_WR), .CMD_ER(C_ER),
		.CMD_OK(C_OK), .CMD_LK(C_LK)) u_dev (.tick(mclk), .pins(pins_q), .dq_wire(dq_in),
		.dq_drv(dq_drv), .dq_en(dq_en), .sts_low(sts_low));
	// released bus drifts, so a stale value never reads back as good data
	assign dq_in = dq_oe ? dq_out : (dq_en ? dq_drv : ~dq_last);

	always #50 mclk = ~mclk;

	always @(posedge mclk)
	begin
		dq_last <= dq_in;
		chk_d <= chk;
		if (chk_d)
		begin
			e = exp_q.pop_front();
			tests_run++;
			if (reg_rdata !== e)
			begin
				n_mismatch++;
				$display("wrong value at %0t: got %h want %h", $time, reg_rdata, e);
			end
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic c);
		@(posedge mclk);
		reg_rd <= 1'b1;
		chk <= c;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		chk <= 1'b0;
		@(posedge mclk);
		v = reg_rdata;
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		rd(a, 1'b1);
	endtask

	task automatic wait_st(input int b, input logic val);
		for (int i = 0; i < 60; i++)
		begin
			rd(fca_pkg::REG_STATUS, 1'b0);
			if (v[b] === val)
				return;
		end
		n_mismatch++;
		$display("wrong value at %0t: status wait ran out", $time);
		final_report();
	endtask

	task automatic flash(input logic [20:0] a, input logic [15:0] d, input int b);
		wr(fca_pkg::REG_ADDR, {11'h0, a});
		wr(fca_pkg::REG_WDATA, {16'h0, d});
		wr(fca_pkg::REG_CTRL, cfg | (32'h1 << b));
		wait_st(fca_pkg::ST_CYC_BUSY, 1'b0);
	endtask

	task automatic cmd(input logic [20:0] a, input logic [7:0] c);
		flash(a, {8'h00, c}, fca_pkg::CTRL_GO_WR);
	endtask

	task automatic rd_flash(input logic [20:0] a, input logic [31:0] x);
		flash(a, 16'h0, fca_pkg::CTRL_GO_RD);
		chk_rd(fca_pkg::REG_RDATA, x);
	endtask

	task automatic wait_done();
		wait_st(fca_pkg::ST_DONE, 1'b1);
		wr(fca_pkg::REG_STATUS, 32'h30);
	endtask

	initial
	begin
		mclk = 1'b0;
		rstn = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chk = 1'b0;
		chk_d = 1'b0;
		dq_last = '0;
		cfg = 32'h18;
		rnd = 32'hf1d8;
		n_mismatch = 0;
		tests_run = 0;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		wr(fca_pkg::REG_CTRL, 32'h1);
		chk_rd(fca_pkg::REG_STATUS, 32'h20);
		wr(fca_pkg::REG_STATUS, 32'h30);
		repeat (15) @(posedge mclk);
		chk_rd(4'hf, 32'h0);
		wr(fca_pkg::REG_CTRL, cfg);
		chk_rd(fca_pkg::REG_CTRL, cfg);
		for (int k = 0; k < 2; k++)
		begin
			rnd = xs(rnd);
			ad[k] = {5'(k + 1), rnd[31:17], 1'b0};
			dt[k] = rnd[15:0];
			cmd(ad[k], C_WR);
			flash(ad[k], dt[k], fca_pkg::CTRL_GO_WR);
			wait_done();
		end
		chk_rd(fca_pkg::REG_STATUS, 32'hc);
		rd_flash(ad[0], 32'h80);
		cmd(21'h0, C_ARR);
		rd_flash(ad[0], {16'h0, dt[0]});
		cfg = 32'h08;
		rd_flash(ad[1] | 21'h1, {24'h0, dt[1][15:8]});
		cfg = 32'h18;
		// power-down cuts a running write; its release of the pin is no completion
		cmd(ad[1], C_WR);
		flash(ad[1], dt[1], fca_pkg::CTRL_GO_WR);
		wr(fca_pkg::REG_CTRL, cfg | 32'h4);
		repeat (3) @(posedge mclk);
		wr(fca_pkg::REG_CTRL, cfg);
		repeat (14) @(posedge mclk);
		chk_rd(fca_pkg::REG_STATUS, 32'hc);
		rd_flash(ad[1], {16'h0, dt[1]});
		cmd(ad[0], C_ER);
		cmd(ad[0], C_OK);
		wait_done();
		cmd(21'h0, C_ARR);
		rd_flash(ad[0], 32'hffff);
		rd_flash(ad[1], {16'h0, dt[1]});
		cmd(ad[1], C_LK);
		cmd(ad[1], C_OK);
		wait_done();
		cfg = 32'h10;
		cmd(ad[1], C_ER);
		cmd(ad[1], C_OK);
		cmd(21'h0, C_ARR);
		rd_flash(ad[1], {16'h0, dt[1]});
		cfg = 32'h18;
		cmd(ad[1], C_ER);
		cmd(ad[1], C_OK);
		wait_done();
		cmd(21'h0, C_ARR);
		rd_flash(ad[1], 32'hffff);
		final_report();
	end
endmodule
`default_nettype wire
